// ==== src/iso_tx_irq_event_mask.sv ====
// Function
// - Rising edge of a context completion signal sets that context event flag.
// - Write to event set address sets flags where data bit is one.
// - Flags clear only by writing one at the event clear address.
// - Read of event clear address returns flags ANDed with enable mask.
// - Event word bits 31 to 8 read zero and ignore writes.
// - Eight flags at bits 0 to 7, flag n for context n.
// - Enable mask, written by set and clear addresses, gates summary.
// - Read of mask set or clear address returns the enable mask.
// - Mask bit n gates event flag n.
// - Summary drives external interrupt only with main mask bit 6 set.
// - No external interrupt unless global gate bit 31 is one.
module iso_tx_irq_event_mask #(
  parameter int unsigned NUM_CTX = iso_tx_irq_pkg::NUM_CTX
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Register bus
  input wire iso_tx_irq_pkg::reg_req_t reg_req,
  output logic [31:0] rdata,
  // Context completion signals
  input wire logic [NUM_CTX-1:0] ctx_done,
  // Interrupt outputs
  output logic iso_tx_summary,
  output logic ext_irq,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [NUM_CTX-1:0] flags, next_flags;
  logic [NUM_CTX-1:0] enable, next_enable;
  logic [NUM_CTX-1:0] done_q, next_done_q;
  logic [31:0] main_mask, next_main_mask;
  logic [1:0] status, next_status;
  logic [1:0] irq_mask, next_irq_mask;
  logic [31:0] next_rdata;
  logic next_summary, next_ext_irq, next_irq;
  logic [NUM_CTX-1:0] rise, wset, wclr, mset, mclr;
  logic [1:0] st_evt;
  logic main_wr, status_wr, irq_mask_wr;

  // Per-context edge detect and write decode
  for (genvar i = 0; i < NUM_CTX; i++) begin : g_ctx
    assign rise[i] = ctx_done[i] & ~done_q[i];
    assign wset[i] = reg_req.wr && reg_req.addr == iso_tx_irq_pkg::OFF_EVENT_SET &&
                     reg_req.wdata[i];
    assign wclr[i] = reg_req.wr && reg_req.addr == iso_tx_irq_pkg::OFF_EVENT_CLEAR &&
                     reg_req.wdata[i];
    assign mset[i] = reg_req.wr && reg_req.addr == iso_tx_irq_pkg::OFF_MASK_SET &&
                     reg_req.wdata[i];
    assign mclr[i] = reg_req.wr && reg_req.addr == iso_tx_irq_pkg::OFF_MASK_CLEAR &&
                     reg_req.wdata[i];
    // Every context edge lands in its own flag position
    property p_ctx_edge;
      @(posedge clk) disable iff (!rstn)
        (clk_en && rise[i]) |=> flags[i];
    endproperty
    a_ctx_edge: assert property (p_ctx_edge) else $error("context edge lost");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register decode and next-state logic
  // Writes to the block's own main mask, status and interrupt mask registers
  assign main_wr = reg_req.wr && reg_req.addr == iso_tx_irq_pkg::OFF_MAIN_MASK;
  assign status_wr = reg_req.wr && reg_req.addr == iso_tx_irq_pkg::OFF_STATUS;
  assign irq_mask_wr = reg_req.wr && reg_req.addr == iso_tx_irq_pkg::OFF_IRQ_MASK;

  // Event flags, enable mask and edge detect: next values
  always_comb begin
    next_done_q = ctx_done;
    // Set wins over clear, so an event in the clear cycle is not lost
    next_flags = (flags & ~wclr) | rise | wset;
    next_enable = (enable & ~mclr) | mset;
    next_summary = |(next_flags & next_enable);
  end

  // Event flags, enable mask and edge detect: registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags <= NUM_CTX'(iso_tx_irq_pkg::RST_FLAGS);
      enable <= NUM_CTX'(iso_tx_irq_pkg::RST_ENABLE);
      // Idle level of the completion inputs, so no false edge after reset
      done_q <= '0;
      iso_tx_summary <= 1'b0;
    end else if (clk_en) begin
      flags <= next_flags;
      enable <= next_enable;
      done_q <= next_done_q;
      iso_tx_summary <= next_summary;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main mask and external interrupt: next values
  always_comb begin
    next_main_mask = main_mask;
    if (main_wr) begin
      next_main_mask = reg_req.wdata;
    end
    // Summary enable and global gate must both be one
    next_ext_irq = next_summary && next_main_mask[iso_tx_irq_pkg::POS_SUMMARY] &&
                   next_main_mask[iso_tx_irq_pkg::POS_GLOBAL_GATE];
  end

  // Main mask and external interrupt: registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_mask <= iso_tx_irq_pkg::RST_MAIN_MASK;
      ext_irq <= 1'b0;
    end else if (clk_en) begin
      main_mask <= next_main_mask;
      ext_irq <= next_ext_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status and interrupt line: next values
  always_comb begin
    // Status events: summary rising, external interrupt rising
    st_evt = 2'h0;
    st_evt[iso_tx_irq_pkg::POS_ST_SUMMARY] = next_summary & ~iso_tx_summary;
    st_evt[iso_tx_irq_pkg::POS_ST_PENDING] = next_ext_irq & ~ext_irq;
    next_status = status;
    if (status_wr) begin
      next_status = status & ~reg_req.wdata[1:0];
    end
    // An event in the clear cycle wins over the clear
    next_status = next_status | st_evt;
    next_irq_mask = irq_mask;
    if (irq_mask_wr) begin
      next_irq_mask = reg_req.wdata[1:0];
    end
    next_irq = |(next_status & next_irq_mask);
  end

  // Sticky status and interrupt line: registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= iso_tx_irq_pkg::RST_STATUS;
      irq_mask <= iso_tx_irq_pkg::RST_IRQ_MASK;
      irq <= 1'b0;
    end else if (clk_en) begin
      status <= next_status;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data: next value, zero in every cycle without a read
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_req.rd) begin
      case (reg_req.addr)
        iso_tx_irq_pkg::OFF_EVENT_SET: next_rdata[NUM_CTX-1:0] = flags;
        iso_tx_irq_pkg::OFF_EVENT_CLEAR: next_rdata[NUM_CTX-1:0] = flags & enable;
        iso_tx_irq_pkg::OFF_MASK_SET: next_rdata[NUM_CTX-1:0] = enable;
        iso_tx_irq_pkg::OFF_MASK_CLEAR: next_rdata[NUM_CTX-1:0] = enable;
        iso_tx_irq_pkg::OFF_MAIN_MASK: next_rdata = main_mask;
        iso_tx_irq_pkg::OFF_STATUS: next_rdata[1:0] = status;
        iso_tx_irq_pkg::OFF_IRQ_MASK: next_rdata[1:0] = irq_mask;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data register, valid only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_edge_sets;
    @(posedge clk) disable iff (!rstn)
      (clk_en && rise[0]) |=> flags[0];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

  property p_set_write;
    @(posedge clk) disable iff (!rstn)
      (clk_en && wset != '0) |=> ((flags & $past(wset)) == $past(wset));
  endproperty
  a_set_write: assert property (p_set_write) else $error("set write lost");

  property p_sticky;
    @(posedge clk) disable iff (!rstn)
      (clk_en && flags[1] && !wclr[1]) |=> flags[1];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared without write");

  property p_clear_read;
    @(posedge clk) disable iff (!rstn)
      (clk_en && reg_req.rd && reg_req.addr == iso_tx_irq_pkg::OFF_EVENT_CLEAR) |=>
        rdata == {24'h000000, $past(flags & enable)};
  endproperty
  a_clear_read: assert property (p_clear_read) else $error("masked read wrong");

  property p_reserved;
    @(posedge clk) disable iff (!rstn)
      (clk_en && reg_req.rd && reg_req.addr == iso_tx_irq_pkg::OFF_EVENT_SET) |=>
        rdata[31:8] == 24'h000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_mask_read;
    @(posedge clk) disable iff (!rstn)
      (clk_en && reg_req.rd && reg_req.addr == iso_tx_irq_pkg::OFF_MASK_CLEAR) |=>
        rdata[7:0] == $past(enable);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong");

  property p_summary;
    @(posedge clk) disable iff (!rstn)
      iso_tx_summary == |(flags & enable);
  endproperty
  a_summary: assert property (p_summary) else $error("summary wrong");

  property p_gate;
    @(posedge clk) disable iff (!rstn)
      ext_irq |-> (main_mask[iso_tx_irq_pkg::POS_GLOBAL_GATE] &&
                   main_mask[iso_tx_irq_pkg::POS_SUMMARY] && iso_tx_summary);
  endproperty
  a_gate: assert property (p_gate) else $error("irq without gates");

  property p_mask_clr;
    @(posedge clk) disable iff (!rstn)
      (clk_en && mclr[2] && !mset[2]) |=> !enable[2];
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask clear failed");

  // Whole-word checks of the event flags and enable mask, except the mask set check on bit 2 only
  property p_no_hw_clear;
    @(posedge clk) disable iff (!rstn)
      (clk_en && wclr == '0) |=> ((flags & $past(flags)) == $past(flags));
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag lost");

  property p_zero_write;
    @(posedge clk) disable iff (!rstn)
      (clk_en && wset == '0 && wclr == '0 && rise == '0) |=> flags == $past(flags);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("flags moved");

  property p_mask_hold;
    @(posedge clk) disable iff (!rstn)
      (clk_en && mset == '0 && mclr == '0) |=> enable == $past(enable);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask moved");

  property p_mask_set;
    @(posedge clk) disable iff (!rstn)
      (clk_en && mset[2]) |=> enable[2];
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask set failed");

  property p_mask_set_read;
    @(posedge clk) disable iff (!rstn)
      (clk_en && reg_req.rd && reg_req.addr == iso_tx_irq_pkg::OFF_MASK_SET) |=>
        rdata == {24'h000000, $past(enable)};
  endproperty
  a_mask_set_read: assert property (p_mask_set_read) else $error("mask read wrong");

  property p_summary_off;
    @(posedge clk) disable iff (!rstn)
      (enable == '0) |-> !iso_tx_summary;
  endproperty
  a_summary_off: assert property (p_summary_off) else $error("summary unmasked");

  // Checks on clock enable, read data and the block's own interrupt registers
  property p_freeze;
    @(posedge clk) disable iff (!rstn)
      !clk_en |=> (flags == $past(flags) && enable == $past(enable) &&
                   status == $past(status) && rdata == $past(rdata));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_idle_rdata;
    @(posedge clk) disable iff (!rstn)
      (clk_en && !reg_req.rd) |=> rdata == 32'h0000_0000;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data without read");

  property p_status_sets;
    @(posedge clk) disable iff (!rstn)
      (clk_en && st_evt != 2'h0) |=> ((status & $past(st_evt)) == $past(st_evt));
  endproperty
  a_status_sets: assert property (p_status_sets) else $error("status event lost");

  property p_irq_level;
    @(posedge clk) disable iff (!rstn)
      irq == |(status & irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt line wrong");

  c_edge: cover property (@(posedge clk) disable iff (!rstn) rise[0] ##1 flags[0]);
  c_ext: cover property (@(posedge clk) disable iff (!rstn) ext_irq);
  c_clear: cover property (@(posedge clk) disable iff (!rstn) flags[3] ##1 !flags[3]);
  c_status: cover property (@(posedge clk) disable iff (!rstn) status[1] ##1 irq);
  c_hold: cover property (@(posedge clk) disable iff (!rstn) !clk_en ##1 clk_en);

endmodule : iso_tx_irq_event_mask

// ==== src/iso_tx_irq_pkg.sv ====
package iso_tx_irq_pkg;

  // Number of isochronous transmit contexts
  localparam int unsigned NUM_CTX = 8;

  // Register offsets
  localparam logic [7:0] OFF_EVENT_SET = 8'h90;
  localparam logic [7:0] OFF_EVENT_CLEAR = 8'h94;
  localparam logic [7:0] OFF_MASK_SET = 8'h98;
  localparam logic [7:0] OFF_MASK_CLEAR = 8'h9c;
  localparam logic [7:0] OFF_MAIN_MASK = 8'hb0;
  localparam logic [7:0] OFF_STATUS = 8'hb4;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hb8;

  // Field positions in the main mask register
  localparam int unsigned POS_SUMMARY = 6;
  localparam int unsigned POS_GLOBAL_GATE = 31;

  // Field positions in the local status register
  localparam int unsigned POS_ST_SUMMARY = 0;
  localparam int unsigned POS_ST_PENDING = 1;
  localparam int unsigned NUM_STATUS = 2;

  // Reset values
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [31:0] RST_MAIN_MASK = 32'h0000_0000;
  localparam logic [1:0] RST_STATUS = 2'h0;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage : iso_tx_irq_pkg

// ==== testbench/iso_tx_irq_event_mask_tb.sv ====
module iso_tx_irq_event_mask_tb;
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////
  // Design ports and counters
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  iso_tx_irq_pkg::reg_req_t reg_req = '0;
  logic [7:0] ctx_done = 8'h00;
  logic [31:0] rdata;
  logic iso_tx_summary;
  logic ext_irq;
  logic irq;
  int err_total = 0;
  int cmp_count = 0;
  // Clock of 100 ns period
  always #50 clk = ~clk;
  iso_tx_irq_event_mask dut_u (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .reg_req(reg_req), .rdata(rdata),
    .ctx_done(ctx_done), .iso_tx_summary(iso_tx_summary), .ext_irq(ext_irq), .irq(irq)
  );
  ////////////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    #1;
  endtask : wr
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk
  task tally_and_finish;
    $display("Compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_set_clear;
    rd_chk(8'h90, 32'h0000_0000);
    wr(8'h90, 32'hffff_ffa5);
    rd_chk(8'h90, 32'h0000_00a5);
    wr(8'h94, 32'h0000_0000);
    rd_chk(8'h90, 32'h0000_00a5);
    wr(8'h94, 32'hffff_ff05);
    rd_chk(8'h90, 32'h0000_00a0);
    $display("t_set_clear done");
  endtask : t_set_clear
  task t_mask;
    wr(8'h98, 32'hffff_ff0f);
    rd_chk(8'h98, 32'h0000_000f);
    rd_chk(8'h9c, 32'h0000_000f);
    check(iso_tx_summary, 32'h0);
    rd_chk(8'h94, 32'h0000_0000);
    wr(8'h98, 32'h0000_0020);
    check(iso_tx_summary, 32'h1);
    rd_chk(8'h94, 32'h0000_0020);
    wr(8'h9c, 32'h0000_0020);
    check(iso_tx_summary, 32'h0);
    $display("t_mask done");
  endtask : t_mask
  task t_edge;
    for (int n = 0; n < 8; n++) begin
      wr(8'h94, 32'h0000_00ff);
      @(posedge clk);
      ctx_done <= 8'h01 << n;
      repeat (2) @(posedge clk);
      rd_chk(8'h90, 32'h1 << n);
      wr(8'h94, 32'h0000_00ff);
      rd_chk(8'h90, 32'h0000_0000);
      @(posedge clk);
      ctx_done <= 8'h00;
    end
    $display("t_edge done");
  endtask : t_edge
  task t_irq;
    wr(8'h90, 32'h0000_0001);
    check(iso_tx_summary, 32'h1);
    rd_chk(8'h94, 32'h0000_0001);
    wr(8'hb0, 32'h0000_0040);
    check(ext_irq, 32'h0);
    wr(8'hb0, 32'h8000_0040);
    check(ext_irq, 32'h1);
    rd_chk(8'hb4, 32'h0000_0003);
    wr(8'hb8, 32'h0000_0002);
    check(irq, 32'h1);
    wr(8'hb8, 32'h0000_0000);
    check(irq, 32'h0);
    wr(8'hb4, 32'h0000_0003);
    wr(8'hb8, 32'h0000_0003);
    check(irq, 32'h0);
    wr(8'hb0, 32'h8000_0000);
    check(ext_irq, 32'h0);
    wr(8'hc0, 32'hffff_ffff);
    rd_chk(8'hc0, 32'h0000_0000);
    $display("t_irq done");
  endtask : t_irq
  // Writes while the clock enable is low must leave all state alone
  task t_hold;
    @(posedge clk);
    clk_en <= 1'b0;
    wr(8'h90, 32'h0000_0080);
    wr(8'h98, 32'h0000_0080);
    check(iso_tx_summary, 32'h1);
    @(posedge clk);
    clk_en <= 1'b1;
    rd_chk(8'h90, 32'h0000_0001);
    rd_chk(8'h98, 32'h0000_000f);
    $display("t_hold done");
  endtask : t_hold
  ////////////////////////////////////////////////////////////////////////
  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_set_clear();
    t_mask();
    t_edge();
    t_irq();
    t_hold();
    tally_and_finish();
  end
  // Watchdog well beyond the roughly 170 cycles of the run
  initial begin
    #2_000_000;
    err_total++;
    tally_and_finish();
  end
endmodule : iso_tx_irq_event_mask_tb
